// ### hw/bccc_pkg.sv
// bccc_pkg: constants, types and helpers of the bridge chopper control
// assumes a single 125 MHz clock domain and a 32-bit apb register bus
package bccc_pkg;

	// clock and timing
	localparam int CLK_MHZ = 125;
	localparam int T_OFF_FIX_US = 30;
	localparam int T_BLANK_NS = 1000;
	localparam int OFF_FIX_CYC = T_OFF_FIX_US * CLK_MHZ;
	localparam int BLANK_CYC = (T_BLANK_NS * CLK_MHZ) / 1000;
	localparam int OFF_RES_DIV = 825;
	localparam int FAST_NUM = 5;
	localparam int FAST_SHIFT = 4;
	localparam int REF_DIV = 8;

	// register offsets, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OFF_RES = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;

	// reset values and field layout
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_DRIVE_EN = 0;
	localparam int OFF_RES_W = 18;
	localparam logic [OFF_RES_W-1:0] OFF_RES_RST = 18'h061A8;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	localparam int IRQ_W = 5;
	localparam int IRQ_SHORT = 0;
	localparam int IRQ_TRIP = 2;
	localparam int IRQ_FAULT = 4;

	// current level codes on the level pins
	localparam logic [1:0] LVL_100 = 2'h0;
	localparam logic [1:0] LVL_66 = 2'h1;
	localparam logic [1:0] LVL_33 = 2'h2;
	localparam logic [1:0] LVL_OFF = 2'h3;
	localparam logic [6:0] PCT_100 = 7'h64;
	localparam logic [6:0] PCT_66 = 7'h42;
	localparam logic [6:0] PCT_33 = 7'h21;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ON = 4'h2,
		ST_FAST = 4'h4,
		ST_SLOW = 4'h8
	} bccc_state_t;

	// gate drive of one full-bridge, high = transistor on
	typedef struct packed {
		logic src_a;
		logic snk_a;
		logic src_b;
		logic snk_b;
	} bccc_gate_t;

	// digital view of one bridge's sense terminal
	typedef struct packed {
		logic trip;
		logic zero;
		logic gnd_short;
	} bccc_sense_t;

	// percentage of full-scale trip for a level code, 0 when disabled
	function automatic logic [6:0] bccc_lvl_pct(input logic [1:0] lvl);
		case (lvl)
			LVL_100: bccc_lvl_pct = PCT_100;
			LVL_66: bccc_lvl_pct = PCT_66;
			LVL_33: bccc_lvl_pct = PCT_33;
			default: bccc_lvl_pct = 7'h00;
		endcase
	endfunction

endpackage

// ### hw/bccc_bridge.sv
// bccc_bridge: fixed off-time chopper of one full-bridge
// assumes all inputs already synchronised to pclk
`timescale 1ns/1ns
module bccc_bridge
	import bccc_pkg::*;
#(
	parameter int CW = 16,
	parameter int BW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic wake_edge,
	input wire logic phase,
	input wire logic [1:0] level,
	input wire bccc_sense_t sense,
	input wire logic [CW-1:0] off_cyc,
	input wire logic [CW-1:0] fast_cyc,
	output bccc_gate_t gate_reg,
	output logic [6:0] pct_reg,
	output logic short_reg,
	output logic trip_evt,
	output bccc_state_t st_reg
);

	generate
		if (BLANK_CYC < 1 || BLANK_CYC >= (1 << BW) || CW < 12)
			$error("bccc_bridge: counter widths too small");
	endgenerate

	bccc_state_t st_next;
	logic [BW-1:0] blank_reg;
	logic [CW-1:0] off_reg;
	logic phase_d_reg;
	logic zc_reg;
	logic go, blank_done, decay, decay_next;

	// disabled level code or a latched short parks the bridge
	assign go = run && !short_reg && level != LVL_OFF;
	assign blank_done = blank_reg == '0;
	assign decay = st_reg == ST_FAST || st_reg == ST_SLOW;
	assign decay_next = st_next == ST_FAST || st_next == ST_SLOW;
	assign trip_evt = st_reg == ST_ON && st_next == ST_FAST;

	// chopping sequence
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: if (go) st_next = ST_ON;
			ST_ON: begin
				if (!go || (blank_done && sense.gnd_short))
					st_next = ST_IDLE;
				else if (blank_done && sense.trip)
					st_next = ST_FAST;
			end
			// >= so an off-time shortened mid-decay cannot wrap the counter
			ST_FAST: begin
				if (!go)
					st_next = ST_IDLE;
				else if (off_reg >= off_cyc)
					st_next = ST_ON;
				else if (off_reg >= fast_cyc)
					st_next = ST_SLOW;
			end
			ST_SLOW: begin
				if (!go)
					st_next = ST_IDLE;
				else if (off_reg >= off_cyc)
					st_next = ST_ON;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_reg <= ST_IDLE;
		else
			st_reg <= st_next;
	end

	// blanking reloads on each switch into the on-phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_reg <= '0;
			phase_d_reg <= 1'b0;
		end else begin
			phase_d_reg <= phase;
			if (st_next == ST_ON && (st_reg != ST_ON || phase != phase_d_reg))
				blank_reg <= BW'(BLANK_CYC - 1);
			else if (!blank_done)
				blank_reg <= blank_reg - 1'b1;
		end
	end

	// off-time counter, one count per decay cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			off_reg <= '0;
		else if (decay_next && !decay)
			off_reg <= CW'(1);
		else if (decay_next)
			off_reg <= off_reg + 1'b1;
		else
			off_reg <= '0;
	end

	// short to ground stays latched until the next wake-up; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			short_reg <= 1'b0;
		else if (st_reg == ST_ON && blank_done && sense.gnd_short && run)
			short_reg <= 1'b1;
		else if (wake_edge)
			short_reg <= 1'b0;
	end

	// zero crossing ends rectification for the rest of the off-time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			zc_reg <= 1'b0;
		else if (decay && sense.zero)
			zc_reg <= 1'b1;
		else if (!decay)
			zc_reg <= 1'b0;
	end

	// gate pattern per state; phase high drives a to b
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_reg <= '0;
			pct_reg <= 7'h00;
		end else begin
			pct_reg <= bccc_lvl_pct(level);
			gate_reg <= '0;
			case (st_reg)
				ST_ON: gate_reg <= phase ? 4'h9 : 4'h6;
				ST_FAST: if (!zc_reg)
					gate_reg <= phase ? 4'h6 : 4'h9;
				ST_SLOW: if (!zc_reg)
					gate_reg <= 4'h5;
				default: gate_reg <= '0;
			endcase
		end
	end

	property p_blank_hold;
		@(posedge pclk) disable iff (!presetn)
		(st_reg == ST_ON && !blank_done && go) |=> st_reg == ST_ON;
	endproperty
	a_blank_hold: assert property (p_blank_hold)
		else $error("trip acted during blanking");

	property p_trip_off;
		@(posedge pclk) disable iff (!presetn)
		(st_reg == ST_ON && blank_done && sense.trip && go &&
			!sense.gnd_short) |=> st_reg == ST_FAST ##1
			gate_reg == (phase_d_reg ? 4'h6 : 4'h9);
	endproperty
	a_trip_off: assert property (p_trip_off)
		else $error("trip did not start the off-time");

	property p_fast_split;
		@(posedge pclk) disable iff (!presetn)
		(st_reg == ST_FAST && go && off_reg == fast_cyc &&
			off_reg < off_cyc) |=> st_reg == ST_SLOW;
	endproperty
	a_fast_split: assert property (p_fast_split)
		else $error("fast decay did not end at its share");

	property p_off_end;
		@(posedge pclk) disable iff (!presetn)
		(decay && go && off_reg == off_cyc) |=> st_reg == ST_ON;
	endproperty
	a_off_end: assert property (p_off_end)
		else $error("bridge not re-enabled after off-time");

	property p_short_hold;
		@(posedge pclk) disable iff (!presetn)
		(short_reg && !wake_edge) |=> short_reg && gate_reg == '0;
	endproperty
	a_short_hold: assert property (p_short_hold)
		else $error("latched short released or driving");

	property p_zero_stop;
		@(posedge pclk) disable iff (!presetn)
		(zc_reg && decay) |=> gate_reg == '0;
	endproperty
	a_zero_stop: assert property (p_zero_stop)
		else $error("rectification kept on after zero");

endmodule // bccc_bridge

// ### hw/bccc_top.sv
// bccc_top: two-bridge current chopper control with apb registers
// assumes pins arrive asynchronously and pclk runs at 125 MHz
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
module bccc_top
	import bccc_pkg::*;
#(
	parameter int CW = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic awake_pin,
	input wire logic [1:0] phase_pin,
	input wire logic [3:0] level_pin,
	input wire bccc_sense_t [1:0] sense_pin,
	input wire logic off_time_set_pin,
	input wire logic overtemp_pin,
	input wire logic sink_gate_supply,
	input wire logic source_gate_reservoir,
	input wire logic supply_lockout,
	output bccc_gate_t [1:0] gate_out,
	output logic [1:0][6:0] trip_pct,
	output logic pump_en,
	output logic regulator_en,
	output logic seq_home,
	output logic irq
);

	localparam int SW = 18;

	generate
		if (CW < 16)
			$error("bccc_top: off-time counter narrower than 16 bits");
	endgenerate

	// byte-lane mask from apb strobes
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = a == REG_CTRL || a == REG_OFF_RES || a == REG_STATUS ||
			a == REG_IRQ_STAT || a == REG_IRQ_MASK;
	endfunction

	logic [SW-1:0] raw, sync1_reg, sync2_reg;
	logic awake, ot, sg_fault, res_uv, lock, strapped;
	logic [1:0] phase;
	logic [3:0] level;
	bccc_sense_t [1:0] sense;
	logic awake_d_reg, wake_edge, fault_any, run;
	logic [31:0] ctrl_reg;
	logic [OFF_RES_W-1:0] off_res_reg;
	logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_evt;
	logic [CW-1:0] off_cyc_reg, fast_cyc_reg;
	logic [1:0] short_l, trip_e;
	bccc_state_t [1:0] st;
	logic wr_en, rd_setup, fault_d_reg;
	logic [31:0] wmask, status_word;

	// two-stage synchroniser for every pin input
	assign raw = {awake_pin, phase_pin, level_pin, sense_pin,
		off_time_set_pin, overtemp_pin, sink_gate_supply,
		source_gate_reservoir, supply_lockout};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
		end
	end

	assign {awake, phase, level, sense, strapped, ot, sg_fault, res_uv,
		lock} = sync2_reg;

	// wake-up edge clears latched shorts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			awake_d_reg <= 1'b0;
		else
			awake_d_reg <= awake;
	end
	assign wake_edge = awake && !awake_d_reg;

	// any fault or sleep removes the run permission of both bridges
	assign fault_any = ot || res_uv || sg_fault || lock;
	assign run = !fault_any && awake && ctrl_reg[CTRL_DRIVE_EN];

	// sleep stops pump and regulator; lockout homes the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pump_en <= 1'b0;
			regulator_en <= 1'b0;
			seq_home <= 1'b1;
		end else begin
			pump_en <= awake;
			regulator_en <= awake && !lock;
			seq_home <= lock;
		end
	end

	// off-time: strap gives the fixed value, else ohms over 825 in us;
	// registered so the divider stays off the chopping path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_cyc_reg <= CW'(OFF_FIX_CYC);
			fast_cyc_reg <= CW'((OFF_FIX_CYC * FAST_NUM) >> FAST_SHIFT);
		end else begin
			if (strapped)
				off_cyc_reg <= CW'(OFF_FIX_CYC);
			else
				off_cyc_reg <= CW'((32'(off_res_reg) * 32'(CLK_MHZ))
					/ 32'(OFF_RES_DIV));
			fast_cyc_reg <= CW'((32'(off_cyc_reg) * 32'(FAST_NUM))
				>> FAST_SHIFT);
		end
	end

	// two bridge choppers; a tiny resistor still yields a usable count
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_br
			bccc_bridge #(
				.CW(CW),
				.BW(8)
			) u_br (
				.pclk(pclk),
				.presetn(presetn),
				.run(run),
				.wake_edge(wake_edge),
				.phase(phase[gi]),
				.level(level[2*gi +: 2]),
				.sense(sense[gi]),
				.off_cyc(off_cyc_reg < CW'(2) ? CW'(2) : off_cyc_reg),
				.fast_cyc(fast_cyc_reg == '0 ? CW'(1) : fast_cyc_reg),
				.gate_reg(gate_out[gi]),
				.pct_reg(trip_pct[gi]),
				.short_reg(short_l[gi]),
				.trip_evt(trip_e[gi]),
				.st_reg(st[gi])
			);
		end
	endgenerate

	// apb: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign wr_en = psel && penable && pwrite && addr_ok(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign wmask = lane_mask(pstrb);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			off_res_reg <= OFF_RES_RST;
			irq_mask_reg <= IRQ_MASK_RST;
		end else if (wr_en) begin
			if (paddr == REG_CTRL)
				ctrl_reg <= (ctrl_reg & ~wmask) | (pwdata & wmask & 32'h1);
			if (paddr == REG_OFF_RES)
				off_res_reg <= OFF_RES_W'((32'(off_res_reg) & ~wmask) |
					(pwdata & wmask));
			if (paddr == REG_IRQ_MASK)
				irq_mask_reg <= IRQ_W'((32'(irq_mask_reg) & ~wmask) |
					(pwdata & wmask));
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_d_reg <= 1'b0;
		else
			fault_d_reg <= fault_any;
	end

	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_SHORT +: 2] = short_l;
		irq_evt[IRQ_TRIP +: 2] = trip_e;
		irq_evt[IRQ_FAULT] = fault_any && !fault_d_reg;
		irq_stat_next = irq_stat_reg;
		if (wr_en && paddr == REG_IRQ_STAT)
			irq_stat_next = irq_stat_reg & ~IRQ_W'(pwdata & wmask);
		irq_stat_next = irq_stat_next | irq_evt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// status word: live faults, latches and chopper states
	assign status_word = {16'h0000, st[1], st[0], short_l, !awake, lock,
		res_uv, sg_fault, ot, fault_any};

	// read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup) begin
			case (paddr)
				REG_CTRL: prdata <= ctrl_reg;
				REG_OFF_RES: prdata <= 32'(off_res_reg);
				REG_STATUS: prdata <= status_word;
				REG_IRQ_STAT: prdata <= 32'(irq_stat_reg);
				REG_IRQ_MASK: prdata <= 32'(irq_mask_reg);
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	property p_fault_off;
		@(posedge pclk) disable iff (!presetn)
		fault_any |-> ##2 (gate_out == '0);
	endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("outputs driven during a fault");

	property p_lockout_home;
		@(posedge pclk) disable iff (!presetn)
		lock |=> seq_home ##1 gate_out == '0;
	endproperty
	a_lockout_home: assert property (p_lockout_home)
		else $error("lockout did not home and disable");

	sequence s_asleep;
		!awake ##1 !awake ##1 !awake;
	endsequence
	property p_sleep_off;
		@(posedge pclk) disable iff (!presetn)
		s_asleep |-> !pump_en && !regulator_en && gate_out == '0;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("sleep left pump, regulator or outputs on");

	property p_strap_time;
		@(posedge pclk) disable iff (!presetn)
		strapped |=> off_cyc_reg == CW'(OFF_FIX_CYC);
	endproperty
	a_strap_time: assert property (p_strap_time)
		else $error("strapped off-time is not the fixed count");

	property p_short_irq;
		@(posedge pclk) disable iff (!presetn)
		$rose(short_l[0]) |=> irq_stat_reg[IRQ_SHORT] ##1
			irq_stat_reg[IRQ_SHORT];
	endproperty
	a_short_irq: assert property (p_short_irq)
		else $error("short event not recorded");

	property p_wake_clear;
		@(posedge pclk) disable iff (!presetn)
		wake_edge |=> short_l == 2'b00;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake-up did not clear the short latch");

	property p_trip_irq;
		@(posedge pclk) disable iff (!presetn)
		trip_e[0] |=> irq_stat_reg[IRQ_TRIP];
	endproperty
	a_trip_irq: assert property (p_trip_irq)
		else $error("trip event not recorded");

	property p_fault_irq;
		@(posedge pclk) disable iff (!presetn)
		(fault_any && !fault_d_reg) |=> irq_stat_reg[IRQ_FAULT];
	endproperty
	a_fault_irq: assert property (p_fault_irq)
		else $error("fault event not recorded");

	property p_sleep_pump;
		@(posedge pclk) disable iff (!presetn)
		!awake |=> !pump_en && !regulator_en;
	endproperty
	a_sleep_pump: assert property (p_sleep_pump)
		else $error("pump or regulator on while asleep");

	property p_home_release;
		@(posedge pclk) disable iff (!presetn)
		!lock |=> !seq_home;
	endproperty
	a_home_release: assert property (p_home_release)
		else $error("sequencer held home without lockout");

	property p_level_off;
		@(posedge pclk) disable iff (!presetn)
		level[1:0] == LVL_OFF |-> ##2 gate_out[0] == '0;
	endproperty
	a_level_off: assert property (p_level_off)
		else $error("disabled level still drives the bridge");

	property p_pct_33;
		@(posedge pclk) disable iff (!presetn)
		level[1:0] == LVL_33 |=> trip_pct[0] == PCT_33;
	endproperty
	a_pct_33: assert property (p_pct_33)
		else $error("low level code gave the wrong percentage");

	property p_pct_66;
		@(posedge pclk) disable iff (!presetn)
		level[1:0] == LVL_66 |=> trip_pct[0] == PCT_66;
	endproperty
	a_pct_66: assert property (p_pct_66)
		else $error("middle level code gave the wrong percentage");

	// fast share follows the strapped off-time one cycle later
	property p_strap_fast;
		@(posedge pclk) disable iff (!presetn)
		strapped |-> ##2
			fast_cyc_reg == CW'((OFF_FIX_CYC * FAST_NUM) >> FAST_SHIFT);
	endproperty
	a_strap_fast: assert property (p_strap_fast)
		else $error("fast decay share of fixed off-time wrong");

endmodule // bccc_top

// ### dv/bccc_step_ctrl_model.sv
// bccc_step_ctrl_model: step controller that feeds the phase and level pins
// assumes the bench asks for phase and level and drives the sleep pin
`timescale 1ns/1ns
module bccc_step_ctrl_model #(
	parameter int WAKE_WAIT = 125000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic awake,
	input wire logic [1:0] want_phase,
	input wire logic [3:0] want_level,
	output logic [1:0] phase_pin,
	output logic [3:0] level_pin
);
	int wait_cnt;
	// level outputs held off after wake-up so the gate supply can settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= 0;
			level_pin <= 4'hF;
			phase_pin <= 2'h0;
		end else if (!awake) begin
			wait_cnt <= 0;
			level_pin <= 4'hF;
		end else if (wait_cnt < WAKE_WAIT) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			level_pin <= want_level;
			phase_pin <= want_phase;
		end
	end
endmodule // bccc_step_ctrl_model

// ### dv/bridge_current_chopper_control_tb_top.sv
// bench of the two-bridge chopper: apb, pins, decay timing and faults
// assumes bccc_pkg and bccc_top are compiled first
`timescale 1ns/1ns
module bridge_current_chopper_control_tb_top
	import bccc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, want_level, level_pin, flt;
	logic [1:0] want_phase, phase_pin;
	logic awake, off_set, pump_en, regulator_en, seq_home, er;
	bccc_sense_t [1:0] sense;
	bccc_gate_t [1:0] gate_out;
	logic [1:0][6:0] trip_pct;
	int failures = 0, check_count = 0, cyc = 0;
	localparam logic [3:0] ON1 = 4'h9, FST1 = 4'h6, SLW = 4'h5;

	bccc_step_ctrl_model #(.WAKE_WAIT(200)) ctl (.pclk(pclk),
		.presetn(presetn), .awake(awake), .want_phase(want_phase),
		.want_level(want_level), .phase_pin(phase_pin),
		.level_pin(level_pin));
	bccc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.awake_pin(awake), .phase_pin(phase_pin), .level_pin(level_pin),
		.sense_pin(sense), .off_time_set_pin(off_set),
		.overtemp_pin(flt[0]), .sink_gate_supply(flt[1]),
		.source_gate_reservoir(flt[2]), .supply_lockout(flt[3]),
		.gate_out(gate_out), .trip_pct(trip_pct), .pump_en(pump_en),
		.regulator_en(regulator_en), .seq_home(seq_home), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard: the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	// one apb transfer; waits for pready, never assumes a latency
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so back-to-back calls never drive psel twice
		@(posedge pclk);
	endtask

	task automatic run_len(input logic [3:0] pat, output int n);
		n = 0;
		while (gate_out[0] === pat && n < 8000) begin
			n++;
			@(posedge pclk);
		end
	endtask

	task automatic wait_pat(input logic [3:0] pat);
		int n;
		n = 0;
		while (gate_out[0] !== pat && n < 8000) begin
			n++;
			@(posedge pclk);
		end
		chk(32'(n < 8000), 32'h1, "gate pattern never seen");
	endtask

	task automatic t_regs();
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, CTRL_RST, "ctrl reset");
		apb(1'b0, REG_OFF_RES, 32'h0);
		chk(rd, 32'(OFF_RES_RST), "off_res reset");
		apb(1'b0, REG_IRQ_MASK, 32'h0);
		chk(rd, 32'h0, "mask reset");
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped error");
		$display("test regs done");
	endtask

	// trip held high: blank, fast, slow, then on again and again
	task automatic t_chop(input int off);
		int a, b, c, k;
		// line up on a fresh decay so the first on-phase is seen whole
		wait_pat(FST1);
		for (k = 0; k < 2; k++) begin
			wait_pat(ON1);
			run_len(ON1, a);
			chk(32'(a >= BLANK_CYC && a <= BLANK_CYC + 2), 32'h1, "blank");
			run_len(FST1, b);
			chk(32'(b), 32'((off * FAST_NUM) >> FAST_SHIFT), "fast");
			run_len(SLW, c);
			chk(32'(b + c), 32'(off), "off-time");
			chk(32'(gate_out[0]), 32'(ON1), "on after off");
		end
		$display("test chop done");
	endtask

	task automatic t_zero();
		wait_pat(SLW);
		sense[0].zero <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(32'(gate_out[0]), 32'h0, "rectify off at zero");
		sense[0].zero <= 1'b0;
		sense[0].trip <= 1'b0;
		wait_pat(ON1);
		$display("test zero done");
	endtask

	task automatic t_levels();
		int c;
		logic [6:0] e;
		// the controller holds its pins off until its wake-up wait ends
		while (level_pin !== want_level)
			@(posedge pclk);
		for (c = 0; c < 4; c++) begin
			want_level <= {2'h0, 2'(c)};
			repeat (7) @(posedge pclk);
			e = (c == 0) ? PCT_100 : (c == 1) ? PCT_66 : (c == 2) ? PCT_33 : 7'h00;
			chk(32'(trip_pct[0]), 32'(e), "level pct");
		end
		chk(32'(gate_out[0]), 32'h0, "level off");
		want_level <= 4'h0;
		wait_pat(ON1);
		$display("test levels done");
	endtask

	task automatic t_faults();
		int i;
		for (i = 0; i < 4; i++) begin
			flt <= 4'(1 << i);
			repeat (5) @(posedge pclk);
			chk(32'(gate_out), 32'h0, "fault gates");
			if (i == 3)
				chk({regulator_en, seq_home}, 32'h1, "lockout");
			flt <= 4'h0;
			wait_pat(ON1);
		end
		$display("test faults done");
	endtask

	task automatic t_sleep_short();
		apb(1'b1, REG_IRQ_MASK, 32'h1);
		repeat (BLANK_CYC + 5) @(posedge pclk);
		sense[0].gnd_short <= 1'b1;
		repeat (5) @(posedge pclk);
		sense[0].gnd_short <= 1'b0;
		repeat (300) @(posedge pclk);
		chk(32'(gate_out[0]), 32'h0, "short latched");
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rd[6]}, 32'h1, "short status");
		chk({31'h0, irq}, 32'h1, "short irq");
		awake <= 1'b0;
		repeat (5) @(posedge pclk);
		chk({pump_en, regulator_en, gate_out}, 32'h0, "sleep");
		awake <= 1'b1;
		wait_pat(ON1);
		apb(1'b1, REG_IRQ_STAT, 32'h1F);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		$display("test sleep_short done");
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		awake = 1'b1;
		off_set = 1'b1;
		flt = 4'h0;
		sense = '0;
		want_phase = 2'h1;
		want_level = 4'h0;
		repeat (2) @(posedge pclk);
		chk({gate_out, seq_home}, 32'h1, "reset outputs");
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_levels();
		t_faults();
		t_sleep_short();
		sense[0].trip <= 1'b1;
		t_chop(OFF_FIX_CYC);
		off_set <= 1'b0;
		apb(1'b1, REG_OFF_RES, 32'h672);
		t_chop((1650 * CLK_MHZ) / OFF_RES_DIV);
		t_zero();
		tally_and_finish();
	end
endmodule // bridge_current_chopper_control_tb_top
